// >>> core/dmarc_chan.sv
`timescale 1ns/100ps
// Contract
// - descriptor read/write relax and nosnoop come from four config bits
// - one config traffic class serves descriptor reads and writes
// - data read attributes come from current descriptor source fields
// - data write attributes come from current descriptor destination fields
// - status bit set on finish-flag, abort, chain, halt, suspend, error
// - status bit raises interrupt unless its mask bit is set
// - interrupt withdrawn once all causing bits are masked or cleared
// - no data read request crosses a 4 KB aligned boundary
// - up to two data reads outstanding per channel
// - no read for next descriptor while current reads are outstanding
// - with prefetch on, follow next pointers and queue fetched ones
// - suspend or abort flushes queue; in-flight fetch result dropped
// - prefetch stops at list end and never chains
// - prefetch off after reset; enabled only by prefetch level field
// - throttle counter loaded with DWord count at each data read
// - counter decrements once per pace value times 4 ns; code decrements at most once per 40 ns clock
// - next data read held until throttle counter is zero
// - throttle touches data reads only
// - pace value zero disables throttling
// - stride descriptor with update flag replaces active pace
// - multicast posted write goes to multicast ports, and upstream unless blocked
// - upstream copy control decides upstream copy of multicast writes
// - claimed unicast to claiming function only, else upstream only
// - software set of run beats same-cycle hardware clear
module dmarc_chan (
   input  wire logic                     pclk,
   input  wire logic                     presetn,
   input  wire logic                     ce,
   input  wire logic                     psel,
   input  wire logic                     penable,
   input  wire logic                     pwrite,
   input  wire logic [7:0]               paddr,
   input  wire logic [31:0]              pwdata,
   output logic      [31:0]              prdata_q,
   output logic                          pready_q,
   output logic                          pslverr_q,
   input  wire logic [4:0]               evt_i,
   input  wire logic [7:0]               err_set_i,
   input  wire logic                     run_clr_i,
   output logic                          run_q,
   output logic                          irq_q,
   output dmarc_pkg::dmarc_attr_t        desc_rd_attr_q,
   output dmarc_pkg::dmarc_attr_t        desc_wr_attr_q,
   input  wire logic                     job_valid_i,
   input  wire dmarc_pkg::dmarc_job_t    job_i,
   output logic                          job_ready_q,
   output dmarc_pkg::dmarc_attr_t        data_wr_attr_q,
   output logic                          rd_req_valid_q,
   output dmarc_pkg::dmarc_rd_req_t      rd_req_q,
   input  wire logic                     rd_req_ready_i,
   input  wire logic                     rd_cpl_i,
   input  wire logic                     pace_upd_i,
   input  wire logic [15:0]              pace_val_i,
   input  wire logic                     pf_next_vld_i,
   input  wire logic [31:0]              pf_next_ptr_i,
   output logic                          pf_req_valid_q,
   output logic      [31:0]              pf_req_addr_q,
   input  wire logic                     pf_req_ready_i,
   input  wire logic                     pf_rsp_valid_i,
   input  wire logic                     pf_rsp_end_i,
   input  wire logic                     pf_pop_i,
   output logic      [1:0]               pf_cnt_q,
   input  wire logic                     wr_valid_i,
   input  wire dmarc_pkg::dmarc_wr_info_t wr_info_i,
   output logic                          route_vld_q,
   output dmarc_pkg::dmarc_route_t       route_q
);

   // ---------------------------------------------------------------
   // apb decode
   // ---------------------------------------------------------------
   logic [9:0]  cfg_q;
   logic [5:0]  sts_q;
   logic [5:0]  msk_q;
   logic [7:0]  err_q;
   logic [7:0]  errmsk_q;
   logic [15:0] pace_q;
   logic        mblk_q;
   logic [31:0] rd_mux;

   wire acc_wait = psel & penable & ~pready_q;
   wire acc_done = psel & penable & pready_q;
   wire wr_acc   = acc_done & pwrite;
   wire hit_cfg  = (paddr == dmarc_pkg::OFS_CFG);
   wire hit_sts  = (paddr == dmarc_pkg::OFS_STS);
   wire hit_msk  = (paddr == dmarc_pkg::OFS_MSK);
   wire hit_err  = (paddr == dmarc_pkg::OFS_ERRSTS);
   wire hit_emsk = (paddr == dmarc_pkg::OFS_ERRMSK);
   wire hit_pace = (paddr == dmarc_pkg::OFS_PACE);
   wire hit_ctl  = (paddr == dmarc_pkg::OFS_CTL);
   wire hit_mc   = (paddr == dmarc_pkg::OFS_MCAST);
   wire hit_any  = hit_cfg | hit_sts | hit_msk | hit_err | hit_emsk |
                   hit_pace | hit_ctl | hit_mc;

   always_comb begin
      rd_mux = 32'h0000_0000;
      if (hit_cfg) begin
         rd_mux[9:0] = cfg_q;
      end else if (hit_sts) begin
         rd_mux[5:0] = sts_q;
      end else if (hit_msk) begin
         rd_mux[5:0] = msk_q;
      end else if (hit_err) begin
         rd_mux[7:0] = err_q;
      end else if (hit_emsk) begin
         rd_mux[7:0] = errmsk_q;
      end else if (hit_pace) begin
         rd_mux[15:0] = pace_q;
      end else if (hit_ctl) begin
         rd_mux[0] = run_q;
      end else if (hit_mc) begin
         rd_mux[0] = mblk_q;
      end
   end

   // one wait state, data and error registered with pready
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_q  <= 1'b0;
         prdata_q  <= 32'h0000_0000;
         pslverr_q <= 1'b0;
      end else if (ce) begin
         pready_q  <= acc_wait;
         prdata_q  <= (acc_wait & ~pwrite) ? rd_mux : 32'h0000_0000;
         pslverr_q <= acc_wait & ~hit_any;
      end
   end

   // ---------------------------------------------------------------
   // configuration, status, run
   // ---------------------------------------------------------------
   wire [5:0] sts_clr = (wr_acc & hit_sts) ? pwdata[5:0] : 6'h00;
   wire [7:0] err_clr = (wr_acc & hit_err) ? pwdata[7:0] : 8'h00;
   wire       err_evt = |(err_set_i & ~errmsk_q);
   wire [5:0] sts_set = {err_evt, evt_i};
   wire [5:0] sts_d   = (sts_q & ~sts_clr) | sts_set;
   wire [7:0] err_d   = (err_q & ~err_clr) | err_set_i;
   wire       run_set = wr_acc & hit_ctl & pwdata[0];
   // software set overrides a same-cycle hardware clear
   wire       run_d   = run_set ? 1'b1 :
                        (wr_acc & hit_ctl) ? 1'b0 :
                        run_clr_i ? 1'b0 : run_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg_q    <= dmarc_pkg::CFG_RESET;
         sts_q    <= dmarc_pkg::STS_RESET;
         msk_q    <= dmarc_pkg::MSK_RESET;
         err_q    <= dmarc_pkg::ERR_RESET;
         errmsk_q <= dmarc_pkg::ERR_RESET;
         mblk_q   <= 1'b0;
         run_q    <= 1'b0;
         irq_q    <= 1'b0;
      end else if (ce) begin
         if (wr_acc & hit_cfg) cfg_q <= pwdata[9:0];
         if (wr_acc & hit_msk) msk_q <= pwdata[5:0];
         if (wr_acc & hit_emsk) errmsk_q <= pwdata[7:0];
         if (wr_acc & hit_mc) mblk_q <= pwdata[0];
         sts_q <= sts_d;
         err_q <= err_d;
         run_q <= run_d;
         irq_q <= |(sts_q & ~msk_q);
      end
   end

   // descriptor attributes straight from config
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         desc_rd_attr_q <= '0;
         desc_wr_attr_q <= '0;
      end else if (ce) begin
         desc_rd_attr_q <= {cfg_q[dmarc_pkg::CFG_DESC_READ_RELAX_ORDER_BIT_POS],
                            cfg_q[dmarc_pkg::CFG_DESC_READ_NOSNOOP_BIT_POS],
                            cfg_q[dmarc_pkg::CFG_TC_LSB +: 3]};
         desc_wr_attr_q <= {cfg_q[dmarc_pkg::CFG_DESC_WRITE_RELAX_ORDER_BIT_POS],
                            cfg_q[dmarc_pkg::CFG_DESC_WRITE_NOSNOOP_BIT_POS],
                            cfg_q[dmarc_pkg::CFG_TC_LSB +: 3]};
      end
   end

   // ---------------------------------------------------------------
   // data read splitter and pacing
   // ---------------------------------------------------------------
   logic [31:0] addr_q;
   logic [15:0] rem_q;
   logic [1:0]  outst_q;
   logic [15:0] thr_q;
   logic [16:0] acc_q;
   dmarc_pkg::dmarc_attr_t src_q;

   wire [10:0] to_bnd  = dmarc_pkg::PAGE_DW - {1'b0, addr_q[11:2]};
   wire        rem_sm  = rem_q < {5'h00, to_bnd};
   wire [10:0] chunk   = rem_sm ? rem_q[10:0] : to_bnd;
   wire        rd_hs   = rd_req_valid_q & rd_req_ready_i;
   wire        pace_on = (pace_q != 16'h0000);
   wire        thr_ok  = ~pace_on | (thr_q == 16'h0000);
   wire        can_iss = (rem_q != 16'h0000) & ~rd_req_valid_q &
                         (outst_q < dmarc_pkg::MAX_OUTST) & thr_ok;
   // a new descriptor waits for all its predecessor's reads
   wire        job_acc = job_valid_i & job_ready_q;
   wire [1:0]  outst_d = outst_q + {1'b0, rd_hs} - {1'b0, rd_cpl_i};
   wire [15:0] rem_d   = rd_hs ? rem_q - {5'h00, rd_req_q.dw} : rem_q;
   wire [16:0] acc_sum = acc_q + dmarc_pkg::UNIT_PER_CLK;
   // a pace below one clock of units still steps once per clock
   wire        thr_tick = pace_on & (thr_q != 16'h0000) &
                          (acc_sum >= {1'b0, pace_q});

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         addr_q         <= 32'h0000_0000;
         rem_q          <= 16'h0000;
         outst_q        <= 2'h0;
         src_q          <= '0;
         data_wr_attr_q <= '0;
         job_ready_q    <= 1'b0;
         rd_req_valid_q <= 1'b0;
         rd_req_q       <= '0;
      end else if (ce) begin
         outst_q     <= outst_d;
         job_ready_q <= ~job_acc & (rem_d == 16'h0000) &
                        (outst_d == 2'h0) & ~rd_req_valid_q;
         if (job_acc) begin
            addr_q         <= job_i.addr;
            rem_q          <= job_i.len_dw;
            src_q          <= job_i.src;
            data_wr_attr_q <= job_i.dst;
         end else begin
            rem_q <= rem_d;
         end
         if (rd_hs) begin
            rd_req_valid_q <= 1'b0;
         end else if (can_iss & ~job_acc) begin
            rd_req_valid_q <= 1'b1;
            rd_req_q       <= {addr_q, chunk, src_q};
            addr_q         <= addr_q + {19'h00000, chunk, 2'h0};
         end
      end
   end

   // only data reads load the throttle; others bypass it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         thr_q <= 16'h0000;
         acc_q <= 17'h00000;
      end else if (ce) begin
         if (rd_hs & pace_on) begin
            thr_q <= {5'h00, rd_req_q.dw};
            acc_q <= 17'h00000;
         end else if (thr_tick) begin
            thr_q <= thr_q - 16'h0001;
            acc_q <= acc_sum - {1'b0, pace_q};
         end else if (thr_q != 16'h0000) begin
            acc_q <= acc_sum;
         end else begin
            acc_q <= 17'h00000;
         end
      end
   end

   // active pace: software write or stride descriptor update
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pace_q <= dmarc_pkg::PACE_RESET;
      end else if (ce) begin
         if (pace_upd_i) begin
            pace_q <= pace_val_i;
         end else if (wr_acc & hit_pace) begin
            pace_q <= pwdata[15:0];
         end
      end
   end

   // ---------------------------------------------------------------
   // descriptor prefetch
   // ---------------------------------------------------------------
   dmarc_pkg::dmarc_pf_state_t pf_st_q;
   logic pf_drop_q;
   logic pf_stop_q;

   wire [1:0] pf_lvl   = cfg_q[dmarc_pkg::CFG_PF_LSB +: 2];
   wire       pf_flush = evt_i[dmarc_pkg::STS_ABORT] |
                         evt_i[dmarc_pkg::STS_SUSP];
   wire       pf_go    = (pf_lvl != 2'h0) & ~pf_stop_q & pf_next_vld_i &
                         (pf_cnt_q < pf_lvl) & ~pf_flush;
   wire       pf_keep  = pf_rsp_valid_i & ~pf_drop_q & ~pf_flush &
                         (pf_st_q == dmarc_pkg::PF_WAIT);
   wire       pf_take  = pf_pop_i & (pf_cnt_q != 2'h0);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pf_st_q        <= dmarc_pkg::PF_IDLE;
         pf_req_valid_q <= 1'b0;
         pf_req_addr_q  <= 32'h0000_0000;
         pf_drop_q      <= 1'b0;
         pf_stop_q      <= 1'b0;
      end else if (ce) begin
         if (run_set) pf_stop_q <= 1'b0;
         case (pf_st_q)
            dmarc_pkg::PF_IDLE: begin
               pf_drop_q <= 1'b0;
               if (pf_go) begin
                  pf_req_valid_q <= 1'b1;
                  pf_req_addr_q  <= pf_next_ptr_i;
                  pf_st_q        <= dmarc_pkg::PF_REQ;
               end
            end
            dmarc_pkg::PF_REQ: begin
               if (pf_req_ready_i) begin
                  pf_req_valid_q <= 1'b0;
                  pf_st_q        <= dmarc_pkg::PF_WAIT;
               end
               if (pf_flush) pf_drop_q <= 1'b1;
            end
            dmarc_pkg::PF_WAIT: begin
               if (pf_flush) pf_drop_q <= 1'b1;
               if (pf_rsp_valid_i) begin
                  pf_st_q <= dmarc_pkg::PF_IDLE;
                  // list end or chain marker halts prefetching
                  if (pf_rsp_end_i) pf_stop_q <= 1'b1;
               end
            end
            default: pf_st_q <= dmarc_pkg::PF_IDLE;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pf_cnt_q <= 2'h0;
      end else if (ce) begin
         if (pf_flush) begin
            pf_cnt_q <= 2'h0;
         end else begin
            pf_cnt_q <= pf_cnt_q + {1'b0, pf_keep} - {1'b0, pf_take};
         end
      end
   end

   // ---------------------------------------------------------------
   // write routing
   // ---------------------------------------------------------------
   wire mc_hit = wr_info_i.posted & (wr_info_i.mc_hit_br |
                                     wr_info_i.mc_hit_nt);
   dmarc_pkg::dmarc_route_t rt_d;

   always_comb begin
      if (mc_hit) begin
         rt_d.upstream = ~mblk_q;
         rt_d.bridge   = wr_info_i.mc_hit_br;
         rt_d.nt       = wr_info_i.mc_hit_nt;
         rt_d.mcast    = 1'b1;
      end else begin
         rt_d.bridge   = wr_info_i.claim_br;
         rt_d.nt       = wr_info_i.claim_nt & ~wr_info_i.claim_br;
         rt_d.upstream = ~wr_info_i.claim_br & ~wr_info_i.claim_nt;
         rt_d.mcast    = 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         route_vld_q <= 1'b0;
         route_q     <= '0;
      end else if (ce) begin
         route_vld_q <= wr_valid_i;
         route_q     <= wr_valid_i ? rt_d : '0;
      end
   end

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   chk_irq_masked: assert property (@(posedge pclk) disable iff (!presetn)
      ce && ((sts_q & ~msk_q) == 6'h00) |=> !irq_q)
      else $error("interrupt held with no unmasked status");
   chk_irq_raise: assert property (@(posedge pclk) disable iff (!presetn)
      ce && ((sts_q & ~msk_q) != 6'h00) |=> irq_q)
      else $error("unmasked status did not raise interrupt");
   chk_page_split: assert property (@(posedge pclk) disable iff (!presetn)
      rd_req_valid_q |->
         ({1'b0, rd_req_q.addr[11:2]} + rd_req_q.dw) <= 11'h400)
      else $error("data read crosses 4 KB boundary");
   chk_outst_max: assert property (@(posedge pclk) disable iff (!presetn)
      outst_q <= 2'h2)
      else $error("more than two reads outstanding");
   chk_job_gate: assert property (@(posedge pclk) disable iff (!presetn)
      job_acc |-> (outst_q == 2'h0) && (rem_q == 16'h0000))
      else $error("descriptor taken with reads outstanding");
   chk_thr_load: assert property (@(posedge pclk) disable iff (!presetn)
      ce && rd_hs && pace_on |=> thr_q == {5'h00, $past(rd_req_q.dw)})
      else $error("throttle not loaded with dword count");
   chk_thr_hold: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(rd_req_valid_q) |->
         $past(pace_q) == 16'h0000 || $past(thr_q) == 16'h0000)
      else $error("data read issued while throttled");
   chk_sts_sticky: assert property (@(posedge pclk) disable iff (!presetn)
      ce && sts_q[0] && !sts_clr[0] |=> sts_q[0])
      else $error("status bit lost without clear");
   chk_run_win: assert property (@(posedge pclk) disable iff (!presetn)
      ce && run_set && run_clr_i |=> run_q)
      else $error("hardware clear beat software run set");
   chk_pf_off: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(pf_req_valid_q) |-> $past(pf_lvl) != 2'h0)
      else $error("prefetch issued while disabled");
   chk_mc_route: assert property (@(posedge pclk) disable iff (!presetn)
      route_vld_q && route_q.mcast |->
         route_q.upstream == !$past(mblk_q))
      else $error("multicast upstream copy ignores control");

endmodule

// >>> pkg/dmarc_pkg.sv
package dmarc_pkg;

   // ---------------------------------------------------------------
   // register offsets (byte addresses)
   // ---------------------------------------------------------------
   localparam logic [7:0] OFS_CFG    = 8'h00;
   localparam logic [7:0] OFS_STS    = 8'h04;
   localparam logic [7:0] OFS_MSK    = 8'h08;
   localparam logic [7:0] OFS_ERRSTS = 8'h0C;
   localparam logic [7:0] OFS_ERRMSK = 8'h10;
   localparam logic [7:0] OFS_PACE   = 8'h14;
   localparam logic [7:0] OFS_CTL    = 8'h18;
   localparam logic [7:0] OFS_MCAST  = 8'h1C;

   // ---------------------------------------------------------------
   // channel_config_register fields
   // ---------------------------------------------------------------
   localparam int CFG_DESC_READ_RELAX_ORDER_BIT_POS = 0;
   localparam int CFG_DESC_READ_NOSNOOP_BIT_POS = 1;
   localparam int CFG_DESC_WRITE_RELAX_ORDER_BIT_POS = 2;
   localparam int CFG_DESC_WRITE_NOSNOOP_BIT_POS = 3;
   localparam int CFG_TC_LSB   = 4;
   localparam int CFG_PF_LSB   = 8;
   localparam logic [9:0] CFG_RESET = 10'h000;

   // status bit positions
   localparam int STS_IOF   = 0;
   localparam int STS_ABORT = 1;
   localparam int STS_CHAIN = 2;
   localparam int STS_HALT  = 3;
   localparam int STS_SUSP  = 4;
   localparam int STS_ERR   = 5;
   localparam int STS_W     = 6;
   localparam int ERR_W     = 8;
   localparam logic [5:0]  STS_RESET  = 6'h00;
   localparam logic [5:0]  MSK_RESET  = 6'h00;
   localparam logic [7:0]  ERR_RESET  = 8'h00;
   localparam logic [15:0] PACE_RESET = 16'h0000;

   // ---------------------------------------------------------------
   // splitting and pacing
   // ---------------------------------------------------------------
   localparam logic [10:0] PAGE_DW     = 11'h400;
   localparam logic [1:0]  MAX_OUTST   = 2'h2;
   localparam int          UNIT_NS     = 4;
   localparam int          CLK_NS      = 40;
   localparam logic [16:0] UNIT_PER_CLK = 17'(CLK_NS / UNIT_NS);

   typedef struct packed {
      logic       relax;
      logic       nosnoop;
      logic [2:0] tc;
   } dmarc_attr_t;

   typedef struct packed {
      logic [31:0] addr;
      logic [15:0] len_dw;
      dmarc_attr_t src;
      dmarc_attr_t dst;
   } dmarc_job_t;

   typedef struct packed {
      logic [31:0] addr;
      logic [10:0] dw;
      dmarc_attr_t attr;
   } dmarc_rd_req_t;

   typedef struct packed {
      logic mc_hit_br;
      logic mc_hit_nt;
      logic claim_br;
      logic claim_nt;
      logic posted;
   } dmarc_wr_info_t;

   typedef struct packed {
      logic upstream;
      logic bridge;
      logic nt;
      logic mcast;
   } dmarc_route_t;

   typedef enum logic [1:0] {PF_IDLE, PF_REQ, PF_WAIT} dmarc_pf_state_t;

endpackage

// >>> verif/dmarc_chan_tb.sv
`timescale 1ns/100ps
module dmarc_chan_tb;
   logic        pclk, presetn, psel, penable, pwrite, run_clr, wr_valid;
   logic        job_valid, rd_ready, rd_cpl, pf_ready, pf_rsp, pf_nv;
   logic        pready_q, pslverr_q, run_q, irq_q, job_ready_q, serr;
   logic        rd_req_valid_q, pf_req_valid_q, route_vld_q, pace_upd;
   logic [7:0]  paddr, err_set;
   logic [4:0]  evt;
   logic [1:0]  pf_cnt;
   logic [15:0] pace_val;
   logic [7:0]  e;
   logic [31:0] pwdata, prdata_q, rd, lfsr_q, pf_addr;
   dmarc_pkg::dmarc_attr_t    da_r, da_w, dw_attr;
   dmarc_pkg::dmarc_job_t     job;
   dmarc_pkg::dmarc_rd_req_t  rd_req_q, rdq[$];
   dmarc_pkg::dmarc_wr_info_t wi;
   dmarc_pkg::dmarc_route_t   route_q;
   time         hs_t[$];
   int          bad_count, cmp_count;
   dmarc_chan dut (.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata_q(prdata_q), .pready_q(pready_q), .pslverr_q(pslverr_q),
      .evt_i(evt), .err_set_i(err_set), .run_clr_i(run_clr), .run_q(run_q),
      .irq_q(irq_q), .desc_rd_attr_q(da_r), .desc_wr_attr_q(da_w),
      .job_valid_i(job_valid), .job_i(job), .job_ready_q(job_ready_q),
      .data_wr_attr_q(dw_attr), .rd_req_valid_q(rd_req_valid_q),
      .rd_req_q(rd_req_q), .rd_req_ready_i(rd_ready), .rd_cpl_i(rd_cpl),
      .pace_upd_i(pace_upd), .pace_val_i(pace_val), .pf_next_vld_i(pf_nv),
      .pf_next_ptr_i(lfsr_q), .pf_req_valid_q(pf_req_valid_q),
      .pf_req_addr_q(pf_addr), .pf_req_ready_i(pf_ready),
      .pf_rsp_valid_i(pf_rsp), .pf_rsp_end_i(1'b0), .pf_pop_i(1'b0),
      .pf_cnt_q(pf_cnt), .wr_valid_i(wr_valid),
      .wr_info_i(wi), .route_vld_q(route_vld_q), .route_q(route_q));
   dmarc_fabric fab (.pclk(pclk), .presetn(presetn), .rd_valid(rd_req_valid_q),
      .rd_ready(rd_ready), .rd_cpl(rd_cpl), .pf_valid(pf_req_valid_q),
      .pf_ready(pf_ready), .pf_rsp(pf_rsp));
   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   function automatic logic [31:0] nx(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   // upper nibble: route bits compared; lower nibble: expected route
   function automatic logic [7:0] exp_route(
      input dmarc_pkg::dmarc_wr_info_t i, input logic sup);
      if (i.posted && (i.mc_hit_br || i.mc_hit_nt))
         return {4'hF, ~sup, i.mc_hit_br, i.mc_hit_nt, 1'b1};
      if (i.claim_br)
         return 8'hF4;
      if (i.claim_nt)
         return 8'hF2;
      return 8'hF8;
   endfunction
   task chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         bad_count++;
         $display("BAD t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      // idle edge first: back-to-back calls never drive psel twice
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk) penable <= 1'b1;
      do @(posedge pclk); while (pready_q !== 1'b1);
      rd = prdata_q;
      serr = pslverr_q;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task report_and_stop;
      $display("bad_count=%0d cmp_count=%0d", bad_count, cmp_count);
      if (bad_count == 0 && cmp_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   always @(posedge pclk)
      if (rd_req_valid_q === 1'b1 && rd_ready === 1'b1) begin
         rdq.push_back(rd_req_q);
         hs_t.push_back($time);
      end
   initial begin
      pclk = 1'b0;
      forever #20 pclk = ~pclk;
   end
   initial begin
      #2000000 bad_count++;
      report_and_stop;
   end
   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial begin
      {presetn, psel, penable, pwrite, run_clr, wr_valid, job_valid} = '0;
      {paddr, err_set, evt, pwdata, job, wi} = '0;
      pf_nv = 1'b1;
      pace_upd = 1'b0;
      pace_val = 16'h000A;
      lfsr_q = 32'h8717;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(1'b0, dmarc_pkg::OFS_CFG, 32'h0);
      chk(rd, 32'(dmarc_pkg::CFG_RESET));
      chk(32'(pf_req_valid_q), 32'h0);
      repeat (4) begin
         lfsr_q = nx(lfsr_q);
         apb(1'b1, dmarc_pkg::OFS_CFG, lfsr_q & 32'h7F);
         repeat (2) @(posedge pclk);
         chk(32'(da_r), 32'({lfsr_q[0], lfsr_q[1], lfsr_q[6:4]}));
         chk(32'(da_w), 32'({lfsr_q[2], lfsr_q[3], lfsr_q[6:4]}));
      end
      apb(1'b0, 8'h40, 32'h0);
      chk({31'h0, serr}, 32'h1);
      for (int i = 0; i < 6; i++) begin
         if (i < 5) evt <= 5'(1 << i);
         else err_set <= 8'h01;
         @(posedge pclk);
         evt <= 5'h00;
         err_set <= 8'h00;
         repeat (3) @(posedge pclk);
         chk(32'(irq_q), 32'h1);
         apb(1'b1, dmarc_pkg::OFS_MSK, 32'(1 << i));
         repeat (2) @(posedge pclk);
         chk(32'(irq_q), 32'h0);
         if (i == 5) apb(1'b1, dmarc_pkg::OFS_ERRSTS, 32'h1);
         apb(1'b0, dmarc_pkg::OFS_STS, 32'h0);
         chk(rd, 32'(1 << i));
         apb(1'b1, dmarc_pkg::OFS_MSK, 32'h0);
         apb(1'b1, dmarc_pkg::OFS_STS, 32'(1 << i));
         repeat (2) @(posedge pclk);
         chk(32'(irq_q), 32'h0);
      end
      // clear held through the write edge: the write must win
      run_clr <= 1'b1;
      apb(1'b1, dmarc_pkg::OFS_CTL, 32'h1);
      run_clr <= 1'b0;
      @(posedge pclk);
      chk(32'(run_q), 32'h1);
      for (int p = 0; p < 2; p++) begin
         // second pass: stride update sets a pace of one step per clock
         if (p == 1) begin
            pace_upd <= 1'b1;
            @(posedge pclk);
            pace_upd <= 1'b0;
            apb(1'b0, dmarc_pkg::OFS_PACE, 32'h0);
            chk(rd, 32'(pace_val));
         end
         rdq.delete();
         hs_t.delete();
         lfsr_q = nx(lfsr_q);
         job <= {32'h0000_0FF0, 16'h0008, lfsr_q[9:0]};
         job_valid <= 1'b1;
         do @(posedge pclk); while (job_ready_q !== 1'b1);
         job_valid <= 1'b0;
         @(posedge pclk);
         chk(32'(dw_attr), 32'(lfsr_q[4:0]));
         for (int k = 0; k < 200 && rdq.size() < 2; k++) @(posedge pclk);
         chk(32'(rdq.size()), 32'h2);
         if (rdq.size() == 2) begin
            chk(rdq[0].addr, 32'h0000_0FF0);
            chk(rdq[1].addr, 32'h0000_1000);
            chk({rdq[0].dw, rdq[0].attr}, {11'h4, lfsr_q[9:5]});
            chk({rdq[1].dw, rdq[1].attr}, {11'h4, lfsr_q[9:5]});
            // 4 dwords at 40 ns a step hold the next read over 160 ns
            if (p == 1) chk(32'(hs_t[1] - hs_t[0] > 160), 32'h1);
         end
      end
      repeat (16) begin
         lfsr_q = nx(lfsr_q);
         apb(1'b1, dmarc_pkg::OFS_MCAST, 32'(lfsr_q[5]));
         wi <= lfsr_q[4:0];
         wr_valid <= 1'b1;
         @(posedge pclk);
         wr_valid <= 1'b0;
         @(posedge pclk);
         e = exp_route(wi, lfsr_q[5]);
         chk(32'(route_vld_q), 32'h1);
         chk(32'(route_q & e[7:4]), 32'(e[3:0]));
      end
      // two-deep prefetch fills, then an abort empties the queue
      apb(1'b1, dmarc_pkg::OFS_CFG, 32'h0000_0200);
      repeat (12) @(posedge pclk);
      chk(32'(pf_cnt), 32'h2);
      chk(pf_addr, lfsr_q);
      evt <= 5'h02;
      @(posedge pclk);
      evt <= 5'h00;
      @(posedge pclk);
      chk(32'(pf_cnt), 32'h0);
      report_and_stop;
   end
endmodule

// >>> verif/dmarc_fabric.sv
`timescale 1ns/100ps
module dmarc_fabric (
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic rd_valid,
   output logic      rd_ready,
   output logic      rd_cpl,
   input  wire logic pf_valid,
   output logic      pf_ready,
   output logic      pf_rsp
);
   logic [3:0] lfsr_q;
   logic [3:0] cpl_q;
   // completions lag so a second read can go out before the first ends
   // ready stalls at random so reads may pile up in flight
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lfsr_q <= 4'h9;
         rd_ready <= 1'b0;
         rd_cpl <= 1'b0;
         cpl_q <= 4'h0;
         pf_ready <= 1'b0;
         pf_rsp <= 1'b0;
      end else begin
         lfsr_q <= {lfsr_q[2:0], lfsr_q[3] ^ lfsr_q[2]};
         rd_ready <= rd_valid & lfsr_q[0] & ~rd_ready;
         cpl_q <= {cpl_q[2:0], rd_valid & rd_ready};
         rd_cpl <= cpl_q[3];
         pf_ready <= pf_valid & ~pf_ready;
         pf_rsp <= pf_valid & pf_ready;
      end
   end
endmodule
